/* sim/uad_ctrl_tb.sv */
// Self-checking bench for the accessory detection controller.
`timescale 1ns/100ps
`default_nettype none
module uad_ctrl_tb;
  import uad_pkg::*;
  localparam int MSC = 20;
  typedef struct {
    logic [1:0] port;
    logic ck;
    logic ct;
    int ms;
    logic [2:0] sw;
    logic ckd;
    logic dcd;
  } uad_row_t;
  logic clk, rstn, scl, sda, h_oe, d_out, d_oe, hit, rd, srst, pwr, id, ck, ct, men;
  logic ckd, dcd, int_n, acked;
  logic [1:0] port;
  uad_sw_t msw, sw;
  int fail_count = 0, checks = 0, cyc = 0, hits = 0, srsts = 0;
  uad_row_t rows [9] = '{
    '{2'h1, 1'b0, 1'b1, 118, 3'h0, 1'b0, 1'b0},
    '{2'h1, 1'b0, 1'b1, 122, 3'h7, 1'b0, 1'b0},
    '{2'h2, 1'b0, 1'b1, 158, 3'h0, 1'b0, 1'b0},
    '{2'h2, 1'b0, 1'b1, 162, 3'h7, 1'b0, 1'b0},
    '{2'h3, 1'b0, 1'b1, 162, 3'h4, 1'b0, 1'b0},
    '{2'h0, 1'b1, 1'b1, 138, 3'h0, 1'b0, 1'b0},
    '{2'h0, 1'b1, 1'b1, 142, 3'h0, 1'b1, 1'b0},
    '{2'h0, 1'b0, 1'b0, 598, 3'h0, 1'b0, 1'b0},
    '{2'h0, 1'b0, 1'b0, 602, 3'h0, 1'b0, 1'b1}};
  // Open-drain data line with pull-up.
  assign sda = !(h_oe || (d_oe && !d_out));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  uad_ctrl #(.MS_CYCLES(MSC), .DCD_MS(600)) i_uad_ctrl (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(d_out),
    .o_sda_oe(d_oe), .o_addr_hit(hit), .o_read(rd), .o_self_reset(srst),
    .i_connector_power_in(pwr), .i_connector_id_pin(id), .i_port_type(port),
    .i_carkit(ck), .i_data_contact(ct), .i_manual_switch_enable(men),
    .i_manual_sw(msw), .o_sw(sw), .o_carkit_detected(ckd), .o_dcd_timeout(dcd),
    .o_interrupt_out_n(int_n));
  uad_host_model i_uad_host_model (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
  // Pulse counters and a ceiling well above the expected run of about 53000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (hit === 1'b1) hits++;
    if (srst === 1'b1) srsts++;
    if (cyc == 70000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    rstn = 1'b0; pwr = 1'b0; id = 1'b0; port = 2'h0; ck = 1'b0; ct = 1'b1;
    men = 1'b0; msw = 3'h0;
    step(10);
    chk("sw reset", sw, 3'h0);
    chk("int reset", int_n, 3'h1);
    rstn = 1'b1;
    step(6);
    $display("test reset done");
    foreach (rows[k]) begin
      port = rows[k].port; ck = rows[k].ck; ct = rows[k].ct;
      pwr = 1'b1;
      step(rows[k].ms * MSC);
      chk("sw", sw, rows[k].sw);
      chk("carkit", ckd, rows[k].ckd);
      chk("dcd timeout", dcd, rows[k].dcd);
      pwr = 1'b0;
      step(10);
      chk("sw off", sw, 3'h0);
    end
    $display("test rows done");
    men = 1'b1; msw = 3'h5;
    step(3);
    chk("manual sw", sw, 3'h5);
    // A reset in mid-run must clear the switches, then manual settings apply again.
    rstn = 1'b0;
    step(2);
    chk("sw mid reset", sw, 3'h0);
    chk("int mid reset", int_n, 3'h1);
    rstn = 1'b1;
    step(6);
    chk("manual after reset", sw, 3'h5);
    men = 1'b0;
    step(3);
    chk("auto sw", sw, 3'h0);
    $display("test manual done");
    // Power drops after 100 ms, so the count must start again.
    port = 2'h1; pwr = 1'b1;
    step(100 * MSC);
    pwr = 1'b0;
    step(10);
    pwr = 1'b1;
    step(100 * MSC);
    chk("sw restart", sw, 3'h0);
    step(22 * MSC);
    chk("sw late", sw, 3'h7);
    pwr = 1'b0;
    step(10);
    $display("test restart done");
    id = 1'b1;
    step(148 * MSC);
    chk("int early", int_n, 3'h1);
    step(4 * MSC);
    chk("int low", int_n, 3'h0);
    id = 1'b0;
    step(10);
    chk("int detach", int_n, 3'h1);
    $display("test id done");
    i_uad_host_model.start();
    i_uad_host_model.send_byte({7'h25, 1'b0}, 1'b0, acked);
    chk("ack write", acked, 3'h1);
    chk("read bit", rd, 3'h0);
    i_uad_host_model.start();
    i_uad_host_model.send_byte({7'h25, 1'b1}, 1'b0, acked);
    chk("ack read", acked, 3'h1);
    chk("read bit", rd, 3'h1);
    i_uad_host_model.start();
    i_uad_host_model.send_byte({7'h26, 1'b0}, 1'b0, acked);
    chk("nack other", acked, 3'h0);
    i_uad_host_model.start();
    i_uad_host_model.send_byte({7'h25, 1'b0}, 1'b1, acked);
    chk("ack spike", acked, 3'h1);
    i_uad_host_model.stop();
    chk("hit pulses", 3'(hits), 3'h3);
    $display("test serial done");
    i_uad_host_model.hold_low(29 * MSC);
    chk("hang early", 3'(srsts), 3'h0);
    i_uad_host_model.hold_low(2 * MSC);
    chk("hang reset", 3'(srsts), 3'h1);
    i_uad_host_model.stop();
    $display("test hang done");
    final_report();
  end
endmodule // uad_ctrl_tb
`default_nettype wire

/* sim/uad_host_model.sv */
// Serial bus master model standing in for the host processor.
`timescale 1ns/100ps
`default_nettype none
module uad_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  // Released lines idle high through the pull-up.
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Every change lands a moment after the rising edge.
  task automatic hw(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Release the data line before raising the clock so that a repeated start works mid-transfer.
  task automatic start();
    o_sda_oe = 1'b0;
    hw(4);
    o_scl = 1'b1;
    hw(8);
    o_sda_oe = 1'b1;
    hw(8);
    o_scl = 1'b0;
    hw(4);
  endtask
  // Address byte MSB first; a glitch adds a one-cycle clock spike.
  task automatic send_byte(input logic [7:0] b, input logic glitch, output logic acked);
    for (int i = 7; i >= 0; i--) begin
      o_sda_oe = ~b[i];
      hw(4);
      if (glitch && i == 7) begin
        o_scl = 1'b1;
        hw(1);
        o_scl = 1'b0;
        hw(4);
      end
      o_scl = 1'b1;
      hw(8);
      o_scl = 1'b0;
      hw(4);
    end
    o_sda_oe = 1'b0;
    hw(8);
    o_scl = 1'b1;
    hw(4);
    acked = (i_sda === 1'b0);
    hw(4);
    o_scl = 1'b0;
    hw(4);
  endtask
  // Data rises while the clock is high.
  task automatic stop();
    o_sda_oe = 1'b1;
    hw(4);
    o_scl = 1'b1;
    hw(8);
    o_sda_oe = 1'b0;
    hw(8);
  endtask
  // Both lines low stand for a hung bus.
  task automatic hold_low(input int n);
    o_scl = 1'b0;
    o_sda_oe = 1'b1;
    hw(n);
  endtask
endmodule // uad_host_model
`default_nettype wire

/* verilog/uad_cfg.svh */
// Constants for the accessory detection controller.
`ifndef UAD_CFG_SVH
`define UAD_CFG_SVH
`define UAD_I2C_ADDR 7'h25
`define UAD_CLK_NS 50
`define UAD_MS_NS 1000000
`define UAD_T_HANG_MS 30
`define UAD_T_SDP_MS 120
`define UAD_T_CHG_MS 160
`define UAD_T_CARKIT_MS 140
`define UAD_T_IDCHK_MS 50
`define UAD_ID_CHECKS 3
`define UAD_T_DCD_MS 600
`define UAD_MS_W 10
`define UAD_MS_SAT 10'h3ff
`endif

/* verilog/uad_ctrl.sv */
// Accessory detection control: serial address slave, hang reset, attach timing.
// Function
// R1: Acknowledge serial address 0100101; the eighth address bit selects read or write.
// R2: Self reset after both serial lines stay low for 30 ms.
// R3: Standard port: close FET and data switches 120 ms after power valid.
// R4: Charging or dedicated port: close FET 160 ms after power valid.
// R5: Car kit charger is reported 140 ms after power valid.
// R6: Resistor-only attach without power drives interrupt low after 150 ms.
// R7: Initial resistor detection is three consecutive 50 ms checks.
// R8: Data contact check ends by timeout, nominally 600 ms, if no contact.
// R9: Automatic mode closes data switches for known ports except dedicated port.
// R10: Serial inputs ignore spikes of one clock period or less.
// R11: Manual enable takes switch settings from the manual inputs.
// R12: One millisecond time base; counters restart when attach condition vanishes.
`timescale 1ns/100ps
`default_nettype none
`include "uad_cfg.svh"
module uad_ctrl import uad_pkg::*; #(
  parameter int MS_CYCLES = `UAD_MS_NS / `UAD_CLK_NS,
  parameter int DCD_MS = `UAD_T_DCD_MS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_addr_hit,
  output logic o_read,
  output logic o_self_reset,
  input wire logic i_connector_power_in,
  input wire logic i_connector_id_pin,
  input wire logic [1:0] i_port_type,
  input wire logic i_carkit,
  input wire logic i_data_contact,
  input wire logic i_manual_switch_enable,
  input wire uad_sw_t i_manual_sw,
  output uad_sw_t o_sw,
  output logic o_carkit_detected,
  output logic o_dcd_timeout,
  output logic o_interrupt_out_n
);
  localparam logic [`UAD_MS_W-1:0] DCD_LIM = DCD_MS[`UAD_MS_W-1:0];
  localparam int TW = $clog2(MS_CYCLES);

  // Timer reaches a millisecond figure; shared by the switch and car kit interval checks.
  function automatic logic reached(input logic [`UAD_MS_W-1:0] ms, input int lim);
    reached = (ms >= lim[`UAD_MS_W-1:0]);
  endfunction

  // Three flops per pin input; the first is read only by the second.
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_last_reg;
  logic sda_last_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
    end
  end

  // A level counts only once stages two and three agree, so a one-cycle spike dies.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin // see R10
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin // see R10
        sda_reg <= sda_sync_reg[2];
      end
      scl_last_reg <= scl_reg;
      sda_last_reg <= sda_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  assign scl_rise = scl_reg && !scl_last_reg;
  assign scl_fall = !scl_reg && scl_last_reg;
  assign start_cond = scl_reg && scl_last_reg && sda_last_reg && !sda_reg;
  assign stop_cond = scl_reg && scl_last_reg && !sda_last_reg && sda_reg;

  // Millisecond time base.
  logic [TW-1:0] tick_cnt_reg;
  logic ms_tick;
  assign ms_tick = (tick_cnt_reg == TW'(MS_CYCLES - 1));
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= ms_tick ? '0 : tick_cnt_reg + 1'b1; // see R12
    end
  end

  // Bus hang: both lines low for the hang time fires a one-cycle self reset.
  logic [`UAD_MS_W-1:0] hang_ms_reg;
  logic hang_fire;
  assign hang_fire = !scl_reg && !sda_reg && ms_tick && (hang_ms_reg == `UAD_T_HANG_MS - 1);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hang_ms_reg <= '0;
      o_self_reset <= 1'b0;
    end else begin
      o_self_reset <= hang_fire; // see R2
      if (scl_reg || sda_reg || hang_fire) begin
        hang_ms_reg <= '0;
      end else if (ms_tick) begin
        hang_ms_reg <= hang_ms_reg + 1'b1; // see R2
      end
    end
  end

  // Address phase: shift seven address bits and the direction bit on rising clock.
  uad_i2c_t i2c_state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      i2c_state_reg <= UAD_I_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      o_sda_oe <= 1'b0;
      o_addr_hit <= 1'b0;
      o_read <= 1'b0;
    end else begin
      o_addr_hit <= 1'b0;
      if (o_self_reset || stop_cond) begin
        i2c_state_reg <= UAD_I_IDLE;
        o_sda_oe <= 1'b0;
      end else if (start_cond) begin
        i2c_state_reg <= UAD_I_ADDR;
        bit_cnt_reg <= 4'h0;
        o_sda_oe <= 1'b0;
      end else begin
        case (i2c_state_reg)
          UAD_I_ADDR: begin
            if (scl_rise && bit_cnt_reg != 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda_reg};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == `UAD_I2C_ADDR) begin // see R1
                i2c_state_reg <= UAD_I_ACK;
                o_sda_oe <= 1'b1;
                o_addr_hit <= 1'b1;
                o_read <= shift_reg[0]; // see R1
              end else begin
                i2c_state_reg <= UAD_I_SKIP;
              end
            end
          end
          UAD_I_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              i2c_state_reg <= UAD_I_SKIP;
            end
          end
          UAD_I_IDLE, UAD_I_SKIP: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            i2c_state_reg <= UAD_I_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // The slave only ever pulls the data line low.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
    end
  end

  // Connector levels come from the analog front end in another domain.
  logic [2:0] pwr_sync_reg;
  logic [2:0] id_sync_reg;
  logic pwr_ok_reg;
  logic id_on_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_sync_reg <= 3'h0;
      id_sync_reg <= 3'h0;
      pwr_ok_reg <= 1'b0;
      id_on_reg <= 1'b0;
    end else begin
      pwr_sync_reg <= {pwr_sync_reg[1:0], i_connector_power_in};
      id_sync_reg <= {id_sync_reg[1:0], i_connector_id_pin};
      if (pwr_sync_reg[1] == pwr_sync_reg[2]) begin
        pwr_ok_reg <= pwr_sync_reg[2];
      end
      if (id_sync_reg[1] == id_sync_reg[2]) begin
        id_on_reg <= id_sync_reg[2];
      end
    end
  end

  // Milliseconds since power valid; cleared when power drops or on self reset.
  logic [`UAD_MS_W-1:0] pwr_ms_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_ms_reg <= '0;
    end else if (!pwr_ok_reg || o_self_reset) begin
      pwr_ms_reg <= '0; // see R12
    end else if (ms_tick && pwr_ms_reg != `UAD_MS_SAT) begin
      pwr_ms_reg <= pwr_ms_reg + 1'b1;
    end
  end

  // Automatic switch result from port type and elapsed time.
  uad_port_t port;
  uad_sw_t auto_sw;
  assign port = uad_port_t'(i_port_type);
  always_comb begin
    auto_sw = '0;
    case (port)
      UAD_PORT_SDP: begin
        auto_sw.fet = reached(pwr_ms_reg, `UAD_T_SDP_MS); // see R3
        auto_sw.dp = auto_sw.fet; // see R9
        auto_sw.dm = auto_sw.fet; // see R9
      end
      UAD_PORT_CDP: begin
        auto_sw.fet = reached(pwr_ms_reg, `UAD_T_CHG_MS); // see R4
        auto_sw.dp = auto_sw.fet; // see R9
        auto_sw.dm = auto_sw.fet; // see R9
      end
      UAD_PORT_DCP: begin
        auto_sw.fet = reached(pwr_ms_reg, `UAD_T_CHG_MS); // see R4
      end
      default: begin
        auto_sw = '0;
      end
    endcase
  end

  // Switch outputs, car kit and contact timeout are registered.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sw <= '0;
      o_carkit_detected <= 1'b0;
      o_dcd_timeout <= 1'b0;
    end else begin
      o_sw <= i_manual_switch_enable ? i_manual_sw : auto_sw; // see R11
      o_carkit_detected <= i_carkit && reached(pwr_ms_reg, `UAD_T_CARKIT_MS); // see R5
      o_dcd_timeout <= pwr_ok_reg && !i_data_contact && (pwr_ms_reg >= DCD_LIM); // see R8
    end
  end

  // Resistor attach without power: three checks of one detection period each.
  logic [`UAD_MS_W-1:0] id_ms_reg;
  logic [1:0] id_chk_reg;
  logic id_run;
  assign id_run = id_on_reg && !pwr_ok_reg && !o_self_reset;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      id_ms_reg <= '0;
      id_chk_reg <= 2'h0;
      o_interrupt_out_n <= 1'b1;
    end else if (!id_run) begin
      id_ms_reg <= '0; // see R12
      id_chk_reg <= 2'h0;
      o_interrupt_out_n <= 1'b1;
    end else if (ms_tick && id_chk_reg != `UAD_ID_CHECKS) begin
      if (id_ms_reg == `UAD_T_IDCHK_MS - 1) begin
        id_ms_reg <= '0;
        id_chk_reg <= id_chk_reg + 1'b1; // see R7
        if (id_chk_reg == `UAD_ID_CHECKS - 1) begin
          o_interrupt_out_n <= 1'b0; // see R6
        end
      end else begin
        id_ms_reg <= id_ms_reg + 1'b1;
      end
    end
  end

  // Checks on the timing relations.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_fet_sdp_time: assert property ($rose(o_sw.fet) && !$past(i_manual_switch_enable) // see R3
    && $past(port) == UAD_PORT_SDP |-> $past(pwr_ms_reg) >= `UAD_T_SDP_MS)
    else $error("FET closed early on standard port");
  a_fet_chg_time: assert property ($rose(o_sw.fet) && !$past(i_manual_switch_enable) // see R4
    && ($past(port) == UAD_PORT_CDP || $past(port) == UAD_PORT_DCP)
    |-> $past(pwr_ms_reg) >= `UAD_T_CHG_MS)
    else $error("FET closed early on charging port");
  a_dcp_data_open: assert property (!$past(i_manual_switch_enable) // see R9
    && $past(port) == UAD_PORT_DCP |-> !o_sw.dp && !o_sw.dm)
    else $error("Data switch closed on dedicated port");
  a_manual_follow: assert property (i_manual_switch_enable |=> o_sw == $past(i_manual_sw)) // see R11
    else $error("Manual settings not applied");
  a_carkit_time: assert property ($rose(o_carkit_detected) // see R5
    |-> $past(pwr_ms_reg) >= `UAD_T_CARKIT_MS)
    else $error("Car kit reported early");
  a_dcd_time: assert property ($rose(o_dcd_timeout) |-> $past(pwr_ms_reg) >= DCD_LIM) // see R8
    else $error("Contact timeout early");
  a_int_checks: assert property ($fell(o_interrupt_out_n) |-> id_chk_reg == 2'h3) // see R6
    else $error("Interrupt before three checks");
  a_int_release: assert property (!id_on_reg && !o_interrupt_out_n |=> ##[0:4] o_interrupt_out_n) // see R12
    else $error("Interrupt held after detach");
  a_hang_pulse: assert property (o_self_reset |-> hang_ms_reg == '0 ##1 !o_self_reset) // see R2
    else $error("Self reset not a single pulse");
  a_ack_match: assert property ($rose(o_sda_oe) |-> $past(shift_reg[7:1]) == `UAD_I2C_ADDR) // see R1
    else $error("Acknowledge for foreign address");
  a_spike_filter: assert property ($changed(scl_reg) |-> $past(scl_sync_reg[1]) == scl_reg) // see R10
    else $error("Clock changed without agreement");
  a_sda_filter: assert property ($changed(sda_reg) |-> $past(sda_sync_reg[1]) == sda_reg) // see R10
    else $error("Data changed without agreement");
  c_ack: cover property ($rose(o_sda_oe));
  c_sdp: cover property ($rose(o_sw.dp) && port == UAD_PORT_SDP);
  c_int: cover property ($fell(o_interrupt_out_n));
  c_hang: cover property (o_self_reset);
endmodule // uad_ctrl
`default_nettype wire

/* verilog/uad_pkg.sv */
// Types shared by the accessory detection controller.
package uad_pkg;
  // Port type reported by the charger detection front end.
  typedef enum logic [1:0] {
    UAD_PORT_NONE = 2'h0,
    UAD_PORT_SDP = 2'h1,
    UAD_PORT_CDP = 2'h2,
    UAD_PORT_DCP = 2'h3
  } uad_port_t;
  // Switch settings: charger FET and the two data switches.
  typedef struct packed {
    logic fet;
    logic dp;
    logic dm;
  } uad_sw_t;
  // Address phase of the serial slave.
  typedef enum logic [3:0] {
    UAD_I_IDLE = 4'h1,
    UAD_I_ADDR = 4'h2,
    UAD_I_ACK = 4'h4,
    UAD_I_SKIP = 4'h8
  } uad_i2c_t;
endpackage
